// ---- logic/fif_framer.sv ----
// Purpose: opcode framing and decoding for a serial flash command port
// Assumes: host clock far slower than clock; pins pass two flip-flops
// Notes:   program/erase engine, array and status meaning live outside

`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------
// small fifo in the read data path
// ---------------------------------------------------------------
module fif_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic             flush,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      count_ff;
  logic [AW:0]      nxt_count;
  logic             in_ready_ff;
  logic             out_valid_ff;
  logic             push;
  logic             pop;

  assign push      = in_valid & in_ready_ff;
  assign pop       = out_ready & out_valid_ff;
  assign nxt_count = count_ff + (AW+1)'(push) - (AW+1)'(pop);
  assign in_ready  = in_ready_ff;
  assign out_valid = out_valid_ff;
  assign out_data  = mem[rd_ptr_ff];

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  // ready and valid are registered from the exact next count
  always_ff @(posedge clock) begin
    if (!rst_n || flush) begin
      wr_ptr_ff    <= '0;
      rd_ptr_ff    <= '0;
      count_ff     <= '0;
      in_ready_ff  <= 1'b1;
      out_valid_ff <= 1'b0;
    end else begin
      wr_ptr_ff    <= wr_ptr_ff + AW'(push);
      rd_ptr_ff    <= rd_ptr_ff + AW'(pop);
      count_ff     <= nxt_count;
      in_ready_ff  <= nxt_count != (AW+1)'(DEPTH);
      out_valid_ff <= nxt_count != '0;
    end
  end
endmodule

// Summary of operation
// - all fields move msb first after select
// - opcode sampled one bit per rising clock
// - opcode first, then address/data/both/nothing
// - reads may end at any bit
// - modifying commands need byte-aligned deselect
// - partial program byte: no program, latch kept
// - 06h enable, 50h volatile, 04h disable
// - 05h/35h return status low/high byte
// - 03h reads directly, 0Bh adds dummy byte
// - 4Bh four dummies then unique identifier
// - 3Bh single-line address, dual-line data
// - 3Bh-like 6Bh with quad-line data
// - 92h dual address/mode, dual id bytes
// - 94h quad address/mode, quad id bytes
// - erase opcodes take exactly three address bytes
// - program offset wraps inside 256-byte page
// - dual address: even bits line0, odd line1
// - status and id repeat until deselect
module fif_framer
  import fif_pkg::*;
(
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic         cs_n_pin,
  input  wire logic         sclk_pin,
  input  wire logic [3:0]   io_in,
  output logic      [3:0]   io_out,
  output logic      [3:0]   io_oe,
  input  wire logic [15:0]  status_word,
  input  wire logic [127:0] unique_identifier,
  input  wire logic [7:0]   array_rd_data,
  input  wire logic         array_rd_valid,
  output logic              array_rd_ready,
  output logic              rd_start,
  output logic      [23:0]  rd_addr,
  output logic              rd_stop,
  output logic              cmd_exec,
  output logic              cmd_reject,
  output logic      [7:0]   cmd_opcode,
  output logic      [23:0]  cmd_addr,
  output logic      [7:0]   mode_byte,
  output logic              prog_strobe,
  output logic      [7:0]   prog_data,
  output logic      [7:0]   prog_offset,
  output logic      [7:0]   status_low_byte,
  output logic      [7:0]   status_high_byte,
  output logic              write_enable_latch
);

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  function automatic fif_cmd_type fif_decode(input logic [7:0] op);
    fif_cmd_type c;
    c            = '0;
    c.known      = 1'b1;
    c.aw         = LANE_1;
    c.dw         = LANE_1;
    c.phase      = PH_OUT;
    c.src        = SRC_ARRAY;
    c.addr_bytes = ADDR_BYTES;
    case (op)
      OP_WR_EN, OP_VSR_EN, OP_WR_DIS, OP_DPD: begin
        c.modify     = 1'b1;
        c.addr_bytes = 2'h0;
        c.phase      = PH_NONE;
      end
      OP_ER_4K, OP_ER_32K, OP_ER_64K: begin
        c.modify = 1'b1;
        c.phase  = PH_NONE;
      end
      OP_PROG, OP_QPROG, OP_WR_STAT: begin
        c.modify     = 1'b1;
        c.phase      = PH_IN;
        c.dw         = (op == OP_QPROG) ? LANE_4 : LANE_1;
        c.addr_bytes = (op == OP_WR_STAT) ? 2'h0 : ADDR_BYTES;
      end
      OP_RD_STLO, OP_RD_STHI: begin
        c.addr_bytes = 2'h0;
        c.src        = (op == OP_RD_STLO) ? SRC_STLO : SRC_STHI;
      end
      OP_READ: begin
      end
      OP_FAST: begin
        c.dummy_bytes = DUMMY_ONE;
      end
      OP_DUAL_OUT, OP_QUAD_OUT: begin
        c.dummy_bytes = DUMMY_ONE;
        c.dw          = (op == OP_DUAL_OUT) ? LANE_2 : LANE_4;
      end
      OP_DUAL_IO: begin
        c.mode = 1'b1;
        c.aw   = LANE_2;
        c.dw   = LANE_2;
      end
      OP_ID_DUAL, OP_ID_QUAD: begin
        c.mode = 1'b1;
        c.aw   = (op == OP_ID_DUAL) ? LANE_2 : LANE_4;
        c.dw   = c.aw;
        c.src  = SRC_IDS;
      end
      OP_UID: begin
        c.addr_bytes  = 2'h0;
        c.dummy_bytes = DUMMY_UID;
        c.src         = SRC_UID;
      end
      default: begin
        c.known = 1'b0;
      end
    endcase
    return c;
  endfunction

  // next field once fields up to 'done' are finished
  function automatic fif_state_type fif_after(input fif_cmd_type c, input logic [1:0] done);
    fif_state_type s;
    if (done == 2'h0 && c.addr_bytes != 2'h0) begin
      s = ST_ADDR;
    end else if (done <= 2'h1 && c.mode) begin
      s = ST_MODE;
    end else if (done <= 2'h2 && c.dummy_bytes != 3'h0) begin
      s = ST_DUMMY;
    end else begin
      case (c.phase)
        PH_IN:   s = ST_DIN;
        PH_OUT:  s = ST_DOUT;
        default: s = ST_DONE;
      endcase
    end
    return s;
  endfunction

  function automatic logic [2:0] fif_load(input fif_cmd_type c, input fif_state_type s);
    return (s == ST_ADDR) ? {1'b0, c.addr_bytes} : c.dummy_bytes;
  endfunction

  // ---------------------------------------------------------------
  // pin synchronisers and edge detection
  // ---------------------------------------------------------------
  logic [5:0] sync1_ff;
  logic [5:0] sync2_ff;
  logic       sclk_d_ff;
  logic       cs_d_ff;
  logic       cs_s;
  logic       sclk_s;
  logic [3:0] io_s;
  logic       rise;
  logic       fall;
  logic       cs_rise;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sync1_ff  <= SYNC_RST;
      sync2_ff  <= SYNC_RST;
      sclk_d_ff <= 1'b0;
      cs_d_ff   <= 1'b1;
    end else begin
      sync1_ff  <= {io_in, sclk_pin, cs_n_pin};
      sync2_ff  <= sync1_ff;
      sclk_d_ff <= sync2_ff[1];
      cs_d_ff   <= sync2_ff[0];
    end
  end

  assign cs_s    = sync2_ff[0];
  assign sclk_s  = sync2_ff[1];
  assign io_s    = sync2_ff[5:2];
  assign rise    = sclk_s & ~sclk_d_ff & ~cs_s;
  assign fall    = ~sclk_s & sclk_d_ff & ~cs_s;
  assign cs_rise = cs_s & ~cs_d_ff;

  // ---------------------------------------------------------------
  // input shifter
  // ---------------------------------------------------------------
  fif_state_type state_ff;
  fif_cmd_type   cmd_ff;
  fif_cmd_type   dec_now;
  logic [7:0]    shift_ff;
  logic [3:0]    bits_ff;
  logic [2:0]    clk_cnt_ff;
  logic [2:0]    cnt_ff;
  logic [23:0]   addr_ff;
  logic [7:0]    op_ff;
  logic [7:0]    mode_ff;
  logic          overrun_ff;
  logic [2:0]    lanes_in;
  logic [7:0]    shin;
  logic [3:0]    bits_next;
  logic          byte_done;
  fif_state_type nxt_state;

  assign lanes_in  = (state_ff == ST_DIN) ? cmd_ff.dw : (state_ff == ST_OPC) ? LANE_1 : cmd_ff.aw;
  assign bits_next = bits_ff + {1'b0, lanes_in};
  assign byte_done = bits_next == BYTE_BITS;
  assign dec_now   = fif_decode(shin);

  // higher-order bit rides the higher line
  always_comb begin
    case (lanes_in)
      LANE_2:  shin = {shift_ff[5:0], io_s[1], io_s[0]};
      LANE_4:  shin = {shift_ff[3:0], io_s[3:0]};
      default: shin = {shift_ff[6:0], io_s[0]};
    endcase
  end

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_OPC:   nxt_state = dec_now.known ? fif_after(dec_now, 2'h0) : ST_IGNORE;
      ST_ADDR:  nxt_state = (cnt_ff == 3'h1) ? fif_after(cmd_ff, 2'h1) : ST_ADDR;
      ST_MODE:  nxt_state = fif_after(cmd_ff, 2'h2);
      ST_DUMMY: nxt_state = (cnt_ff == 3'h1) ? fif_after(cmd_ff, 2'h3) : ST_DUMMY;
      default:  nxt_state = state_ff;
    endcase
  end

  // ---------------------------------------------------------------
  // command sequencer; deselect returns to the opcode phase
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n || cs_s) begin
      state_ff   <= ST_OPC;
      cmd_ff     <= '0;
      shift_ff   <= '0;
      bits_ff    <= '0;
      clk_cnt_ff <= '0;
      cnt_ff     <= '0;
      overrun_ff <= 1'b0;
    end else if (rise) begin
      clk_cnt_ff <= clk_cnt_ff + 3'h1;
      case (state_ff)
        ST_IGNORE, ST_DOUT: begin
        end
        ST_DONE: begin
          overrun_ff <= 1'b1;
        end
        default: begin
          shift_ff <= shin;
          bits_ff  <= byte_done ? 4'h0 : bits_next;
          if (byte_done) begin
            state_ff <= nxt_state;
            if (state_ff == ST_OPC) begin
              cmd_ff <= dec_now;
              cnt_ff <= fif_load(dec_now, nxt_state);
            end else if (nxt_state != state_ff) begin
              cnt_ff <= fif_load(cmd_ff, nxt_state);
            end else begin
              cnt_ff <= cnt_ff - 3'h1;
            end
          end
        end
      endcase
    end
  end

  // captured fields are kept past deselect for the engine
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      addr_ff <= '0;
      op_ff   <= '0;
      mode_ff <= '0;
    end else if (rise && byte_done && !cs_s) begin
      case (state_ff)
        ST_OPC:  op_ff <= shin;
        ST_ADDR: addr_ff <= {addr_ff[15:0], shin};
        ST_MODE: mode_ff <= shin;
        default: op_ff <= op_ff;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // data-in phase: program bytes and status write bytes
  // ---------------------------------------------------------------
  logic       din_any_ff;
  logic [7:0] prog_idx_ff;
  logic [1:0] stat_cnt_ff;
  logic       prog_strobe_ff;
  logic [7:0] prog_data_ff;
  logic [7:0] prog_offset_ff;
  logic [7:0] stat_lo_ff;
  logic [7:0] stat_hi_ff;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      din_any_ff     <= 1'b0;
      prog_idx_ff    <= '0;
      stat_cnt_ff    <= '0;
      prog_strobe_ff <= 1'b0;
      prog_data_ff   <= '0;
      prog_offset_ff <= '0;
      stat_lo_ff     <= '0;
      stat_hi_ff     <= '0;
    end else begin
      prog_strobe_ff <= 1'b0;
      if (cs_s) begin
        din_any_ff  <= 1'b0;
        prog_idx_ff <= '0;
        stat_cnt_ff <= '0;
      end else if (rise && byte_done && state_ff == ST_DIN) begin
        din_any_ff <= 1'b1;
        if (op_ff == OP_WR_STAT) begin
          // bytes after the second one are dropped
          if (stat_cnt_ff == 2'h0) begin
            stat_lo_ff <= shin;
          end else if (stat_cnt_ff == 2'h1) begin
            stat_hi_ff <= shin;
          end
          if (stat_cnt_ff != STAT_WR_MAX) begin
            stat_cnt_ff <= stat_cnt_ff + 2'h1;
          end
        end else begin
          prog_strobe_ff <= 1'b1;
          prog_data_ff   <= shin;
          prog_offset_ff <= addr_ff[7:0] + prog_idx_ff;
          prog_idx_ff    <= prog_idx_ff + 8'h01;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // deselect: execute or reject, write enable latch
  // ---------------------------------------------------------------
  logic        aligned;
  logic        complete;
  logic        exec_ok;
  logic        cmd_exec_ff;
  logic        cmd_reject_ff;
  logic [7:0]  cmd_opcode_ff;
  logic [23:0] cmd_addr_ff;
  logic        wel_ff;

  assign aligned  = clk_cnt_ff == 3'h0 && bits_ff == 4'h0;
  assign complete = (state_ff == ST_DONE && !overrun_ff) || (state_ff == ST_DIN && din_any_ff);
  assign exec_ok  = aligned && complete;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cmd_exec_ff   <= 1'b0;
      cmd_reject_ff <= 1'b0;
      cmd_opcode_ff <= '0;
      cmd_addr_ff   <= '0;
      wel_ff        <= 1'b0;
    end else begin
      cmd_exec_ff   <= 1'b0;
      cmd_reject_ff <= 1'b0;
      if (cs_rise && cmd_ff.modify) begin
        cmd_opcode_ff <= op_ff;
        cmd_addr_ff   <= addr_ff;
        if (exec_ok) begin
          cmd_exec_ff <= 1'b1;
          if (op_ff == OP_WR_EN) begin
            wel_ff <= 1'b1;
          end else if (op_ff != OP_VSR_EN && op_ff != OP_DPD) begin
            wel_ff <= 1'b0;
          end
        end else begin
          cmd_reject_ff <= 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // data-out phase on the falling clock
  // ---------------------------------------------------------------
  logic [7:0]  oshift_ff;
  logic [3:0]  obits_ff;
  logic [3:0]  uid_idx_ff;
  logic        id_tog_ff;
  logic [3:0]  io_out_ff;
  logic [3:0]  io_oe_ff;
  logic        fifo_pop;
  logic        fifo_valid;
  logic [7:0]  fifo_data;
  logic [7:0]  nb;
  logic [7:0]  ob;
  logic        dout_d_ff;
  logic        rd_start_ff;
  logic        rd_stop_ff;
  logic [23:0] rd_addr_ff;

  always_comb begin
    case (cmd_ff.src)
      SRC_STLO:  nb = status_word[7:0];
      SRC_STHI:  nb = status_word[15:8];
      SRC_UID:   nb = unique_identifier[{~uid_idx_ff, 3'b000} +: 8];
      SRC_IDS:   nb = id_tog_ff ? DEV_ID_VAL : MFR_ID_VAL;
      SRC_ARRAY: nb = fifo_valid ? fifo_data : FILL_BYTE;
      default:   nb = FILL_BYTE;
    endcase
  end

  assign ob       = (obits_ff == 4'h0) ? nb : oshift_ff;
  assign fifo_pop = fall && state_ff == ST_DOUT && obits_ff == 4'h0 && cmd_ff.src == SRC_ARRAY;

  // a read may stop after any bit: nothing is pending at deselect
  always_ff @(posedge clock) begin
    if (!rst_n || cs_s) begin
      oshift_ff  <= '0;
      obits_ff   <= '0;
      uid_idx_ff <= '0;
      id_tog_ff  <= 1'b0;
      io_out_ff  <= IO_RST;
      io_oe_ff   <= OE_RST;
    end else if (state_ff != ST_DOUT) begin
      io_oe_ff <= OE_RST;
    end else if (fall) begin
      oshift_ff <= ob << cmd_ff.dw;
      obits_ff  <= (obits_ff == 4'h0 ? BYTE_BITS : obits_ff) - {1'b0, cmd_ff.dw};
      if (obits_ff == 4'h0) begin
        uid_idx_ff <= uid_idx_ff + 4'h1;
        id_tog_ff  <= ~id_tog_ff;
      end
      case (cmd_ff.dw)
        LANE_2: begin
          io_out_ff <= {2'b00, ob[7:6]};
          io_oe_ff  <= OE_LANE_2;
        end
        LANE_4: begin
          io_out_ff <= ob[7:4];
          io_oe_ff  <= OE_LANE_4;
        end
        default: begin
          io_out_ff <= {2'b00, ob[7], 1'b0};
          io_oe_ff  <= OE_LANE_1;
        end
      endcase
    end
  end

  // array read request once the data-out phase begins
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      dout_d_ff   <= 1'b0;
      rd_start_ff <= 1'b0;
      rd_stop_ff  <= 1'b0;
      rd_addr_ff  <= '0;
    end else begin
      dout_d_ff   <= state_ff == ST_DOUT && cmd_ff.src == SRC_ARRAY;
      rd_start_ff <= state_ff == ST_DOUT && cmd_ff.src == SRC_ARRAY && !dout_d_ff;
      rd_stop_ff  <= cs_rise && dout_d_ff;
      if (state_ff == ST_DOUT && !dout_d_ff) begin
        rd_addr_ff <= addr_ff;
      end
    end
  end

  fif_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_rd_fifo (
    .clock     (clock),
    .rst_n     (rst_n),
    .flush     (cs_s),
    .in_data   (array_rd_data),
    .in_valid  (array_rd_valid),
    .in_ready  (array_rd_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  assign io_out             = io_out_ff;
  assign io_oe              = io_oe_ff;
  assign rd_start           = rd_start_ff;
  assign rd_addr            = rd_addr_ff;
  assign rd_stop            = rd_stop_ff;
  assign cmd_exec           = cmd_exec_ff;
  assign cmd_reject         = cmd_reject_ff;
  assign cmd_opcode         = cmd_opcode_ff;
  assign cmd_addr           = cmd_addr_ff;
  assign mode_byte          = mode_ff;
  assign prog_strobe        = prog_strobe_ff;
  assign prog_data          = prog_data_ff;
  assign prog_offset        = prog_offset_ff;
  assign status_low_byte    = stat_lo_ff;
  assign status_high_byte   = stat_hi_ff;
  assign write_enable_latch = wel_ff;

endmodule

`default_nettype wire

// ---- logic/fif_pkg.sv ----
// Purpose: shared constants and types of the serial flash instruction framer
// Assumes: one system clock, pins sampled through two-stage synchronisers
// Notes:   opcodes, lane widths, output sources and reset values live here

`default_nettype none

package fif_pkg;

  // ---------------------------------------------------------------
  // opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_WR_EN    = 8'h06;
  localparam logic [7:0] OP_VSR_EN   = 8'h50;
  localparam logic [7:0] OP_WR_DIS   = 8'h04;
  localparam logic [7:0] OP_RD_STLO  = 8'h05;
  localparam logic [7:0] OP_RD_STHI  = 8'h35;
  localparam logic [7:0] OP_WR_STAT  = 8'h01;
  localparam logic [7:0] OP_READ     = 8'h03;
  localparam logic [7:0] OP_FAST     = 8'h0B;
  localparam logic [7:0] OP_DUAL_OUT = 8'h3B;
  localparam logic [7:0] OP_DUAL_IO  = 8'hBB;
  localparam logic [7:0] OP_QUAD_OUT = 8'h6B;
  localparam logic [7:0] OP_UID      = 8'h4B;
  localparam logic [7:0] OP_ID_DUAL  = 8'h92;
  localparam logic [7:0] OP_ID_QUAD  = 8'h94;
  localparam logic [7:0] OP_ER_4K    = 8'h20;
  localparam logic [7:0] OP_ER_32K   = 8'h52;
  localparam logic [7:0] OP_ER_64K   = 8'hD8;
  localparam logic [7:0] OP_PROG     = 8'h02;
  localparam logic [7:0] OP_QPROG    = 8'h32;
  localparam logic [7:0] OP_DPD      = 8'hB9;

  // ---------------------------------------------------------------
  // field sizes and lane widths
  // ---------------------------------------------------------------
  localparam logic [1:0] ADDR_BYTES  = 2'h3;
  localparam logic [2:0] DUMMY_ONE   = 3'h1;
  localparam logic [2:0] DUMMY_UID   = 3'h4;
  localparam logic [3:0] BYTE_BITS   = 4'h8;
  localparam logic [2:0] LANE_1      = 3'h1;
  localparam logic [2:0] LANE_2      = 3'h2;
  localparam logic [2:0] LANE_4      = 3'h4;
  localparam logic [3:0] OE_LANE_1   = 4'h2;
  localparam logic [3:0] OE_LANE_2   = 4'h3;
  localparam logic [3:0] OE_LANE_4   = 4'hF;
  localparam logic [1:0] STAT_WR_MAX = 2'h2;
  localparam logic [7:0] FILL_BYTE   = 8'hFF;
  localparam int         FIFO_WIDTH  = 8;
  localparam int         FIFO_DEPTH  = 4;

  // identification bytes, values arbitrary
  localparam logic [7:0] MFR_ID_VAL  = 8'h5A;
  localparam logic [7:0] DEV_ID_VAL  = 8'hA5;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [5:0] SYNC_RST    = 6'h01;
  localparam logic [3:0] OE_RST      = 4'h0;
  localparam logic [3:0] IO_RST      = 4'h0;

  typedef enum logic [2:0] {
    ST_OPC    = 3'b000,
    ST_ADDR   = 3'b001,
    ST_MODE   = 3'b010,
    ST_DUMMY  = 3'b011,
    ST_DIN    = 3'b100,
    ST_DOUT   = 3'b101,
    ST_DONE   = 3'b110,
    ST_IGNORE = 3'b111
  } fif_state_type;

  typedef enum logic [2:0] {
    SRC_NONE  = 3'b000,
    SRC_STLO  = 3'b001,
    SRC_STHI  = 3'b010,
    SRC_UID   = 3'b011,
    SRC_ARRAY = 3'b100,
    SRC_IDS   = 3'b101
  } fif_src_type;

  typedef enum logic [1:0] {
    PH_NONE = 2'b00,
    PH_IN   = 2'b01,
    PH_OUT  = 2'b10
  } fif_phase_type;

  typedef struct packed {
    logic          known;
    logic          modify;
    logic [1:0]    addr_bytes;
    logic          mode;
    logic [2:0]    dummy_bytes;
    logic [2:0]    aw;
    logic [2:0]    dw;
    fif_phase_type phase;
    fif_src_type   src;
  } fif_cmd_type;

endpackage

`default_nettype wire

// ---- sim/fif_framer_chk.sv ----
// Purpose: port assertions of the instruction framer
// Assumes: one clock domain, synchronous reset
// Notes:   bound to every framer instance
`timescale 1ns/1ps
`default_nettype none
module fif_framer_chk
  import fif_pkg::*;
(
  input wire logic       clock,
  input wire logic       rst_n,
  input wire logic       cs_n_pin,
  input wire logic [3:0] io_oe,
  input wire logic       cmd_exec,
  input wire logic       cmd_reject,
  input wire logic [7:0] cmd_opcode,
  input wire logic       rd_start,
  input wire logic       write_enable_latch
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_exec_rej_excl: assert property (!(cmd_exec && cmd_reject)) else $error("exec with reject");
  a_exec_pulse: assert property (cmd_exec |=> !cmd_exec) else $error("exec too long");
  a_end_desel: assert property ((cmd_exec || cmd_reject) |-> cs_n_pin) else $error("end while selected");
  a_oe_legal: assert property (io_oe inside {4'h0, 4'h2, 4'h3, 4'hF}) else $error("bad enable");
  a_oe_release: assert property (cs_n_pin [*5] |=> io_oe == 4'h0) else $error("oe after deselect");
  a_read_sel: assert property (rd_start |-> !cs_n_pin) else $error("read start idle");
  a_latch_set: assert property ($rose(write_enable_latch) |-> cmd_exec && cmd_opcode == OP_WR_EN)
    else $error("latch set wrongly");
  a_latch_clr: assert property ($fell(write_enable_latch) |-> cmd_exec && cmd_opcode != OP_WR_EN)
    else $error("latch cleared wrongly");
endmodule
bind fif_framer fif_framer_chk fif_framer_chk_i (.clock, .rst_n, .cs_n_pin, .io_oe, .cmd_exec, .cmd_reject,
  .cmd_opcode, .rd_start, .write_enable_latch);
`default_nettype wire

// ---- sim/fif_framer_test.sv ----
// Purpose: self-checking bench of the instruction framer
// Assumes: host model on the pins, byte source on the read side
// Notes:   pulses are counted by a monitor and compared after one or more frames
`timescale 1ns/1ps
`default_nettype none
module fif_framer_test
  import fif_pkg::*;
;
  logic clock, rst_n, cs_n_pin, sclk_pin, array_rd_valid, array_rd_ready, rd_start, rd_stop, tk;
  logic cmd_exec, cmd_reject, prog_strobe, write_enable_latch;
  logic [3:0] io_in, io_out, io_oe, oe_or;
  logic [7:0] array_rd_data, cmd_opcode, prog_data, prog_offset, status_low_byte, status_high_byte;
  logic [15:0] status_word, rq;
  logic [23:0] rd_addr, cmd_addr;
  logic [127:0] unique_identifier;
  int err_count, total_checks, n_exec, n_rej, n_prog, cyc;

  fif_framer fif_framer_i (.clock, .rst_n, .cs_n_pin, .sclk_pin, .io_in, .io_out, .io_oe, .status_word,
    .unique_identifier, .array_rd_data, .array_rd_valid, .array_rd_ready, .rd_start, .rd_addr, .rd_stop,
    .cmd_exec, .cmd_reject, .cmd_opcode, .cmd_addr, .mode_byte(), .prog_strobe, .prog_data, .prog_offset,
    .status_low_byte, .status_high_byte, .write_enable_latch);
  fif_host fif_host_i (.cs_n_pin, .sclk_pin, .io_in, .io_out, .io_oe);

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  always @(posedge clock) begin
    cyc++;
    n_exec += cmd_exec;
    n_rej += cmd_reject;
    n_prog += prog_strobe;
    oe_or = oe_or | io_oe;
    tk = array_rd_valid && array_rd_ready;
    if (cyc == 20000) begin
      err_count++;
      conclude();
    end
  end

  // byte source counts up from the read address
  always @(negedge clock) begin
    if (rd_start) begin
      array_rd_valid = 1'b1;
      array_rd_data = rd_addr[7:0];
    end else if (tk) array_rd_data = array_rd_data + 8'h01;
    if (rd_stop) array_rd_valid = 1'b0;
  end

  task automatic chk(input string nm, input logic [23:0] s, input logic [23:0] e);
    total_checks++;
    if (s !== e) begin
      err_count++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask

  task automatic cnt(input int e, input int r);
    chk("exec", 24'(n_exec), 24'(e));
    chk("rej", 24'(n_rej), 24'(r));
    n_exec = 0;
    n_rej = 0;
  endtask

  task automatic t_latch();
    fif_host_i.frame(64'h06, 8, 0, rq);
    cnt(1, 0);
    chk("opc", cmd_opcode, OP_WR_EN);
    fif_host_i.frame(64'h08, 9, 0, rq);
    cnt(0, 1);
    chk("wel", write_enable_latch, 1'b1);
    fif_host_i.frame(64'h04, 8, 0, rq);
    fif_host_i.frame(64'h50, 8, 0, rq);
    cnt(2, 0);
    chk("wel", write_enable_latch, 1'b0);
  endtask

  task automatic t_status();
    fif_host_i.frame(64'h05, 8, 12, rq);
    chk("st1", rq[11:0], 12'h5A5);
    fif_host_i.frame(64'h35, 8, 16, rq);
    chk("st2", rq, 16'hC3C3);
    cnt(0, 0);
    fif_host_i.frame(64'h06, 8, 0, rq);
    fif_host_i.frame(64'h013CA5, 24, 0, rq);
    cnt(2, 0);
    chk("slo", status_low_byte, 8'h3C);
    chk("shi", status_high_byte, 8'hA5);
  endtask

  task automatic t_prog();
    fif_host_i.frame(64'h06, 8, 0, rq);
    fif_host_i.frame((64'h020012F0A5 << 3) | 64'h5, 43, 0, rq);
    cnt(1, 1);
    chk("pdat", prog_data, 8'hA5);
    chk("poff", prog_offset, 8'hF0);
    chk("wel", write_enable_latch, 1'b1);
    fif_host_i.frame(64'h020012FFA53C, 48, 0, rq);
    cnt(1, 0);
    chk("prg", 24'(n_prog), 24'h3);
    chk("poff", prog_offset, 8'h00);
    chk("wel", write_enable_latch, 1'b0);
  endtask

  task automatic t_erase();
    logic [7:0] ops [3];
    ops = '{OP_ER_4K, OP_ER_32K, OP_ER_64K};
    foreach (ops[i]) begin
      fif_host_i.frame(64'h06, 8, 0, rq);
      fif_host_i.frame({ops[i], 24'h031000}, 32, 0, rq);
      cnt(2, 0);
      chk("eop", cmd_opcode, ops[i]);
      chk("ead", cmd_addr, 24'h031000);
    end
  endtask

  task automatic t_read();
    fif_host_i.frame({OP_READ, 24'h0400A7}, 32, 8, rq);
    chk("rd", rq[7:0], 8'hA7);
    chk("rad", rd_addr, 24'h0400A7);
    fif_host_i.frame({OP_FAST, 24'h0400B2, 8'h00}, 40, 16, rq);
    chk("fast", rq, 16'hB2B3);
    fif_host_i.frame({OP_UID, 32'h0}, 40, 16, rq);
    chk("uid", rq, 16'h9D4E);
    cnt(0, 0);
  endtask

  task automatic t_lanes();
    oe_or = 4'h0;
    fif_host_i.frame(64'hFF, 8, 8, rq);
    chk("oe0", oe_or, 4'h0);
    fif_host_i.frame({OP_ID_DUAL, 16'h0}, 24, 8, rq);
    chk("id2", rq[7:0], 8'h3C);
    fif_host_i.frame({OP_DUAL_OUT, 32'h0}, 40, 4, rq);
    chk("oe2", oe_or, 4'h3);
    fif_host_i.frame({OP_QUAD_OUT, 32'h0}, 40, 4, rq);
    chk("oe4", oe_or, 4'hF);
    fif_host_i.frame({OP_ID_QUAD, 8'h0}, 16, 8, rq);
    chk("id4", rq[7:0], 8'h66);
    cnt(0, 0);
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    array_rd_valid = 1'b0;
    array_rd_data = 8'h00;
    status_word = 16'hC35A;
    unique_identifier = {16'h9D4E, 112'h0};
    repeat (5) @(negedge clock);
    rst_n = 1'b1;
    repeat (5) @(negedge clock);
    t_latch();
    t_status();
    t_prog();
    t_erase();
    t_read();
    t_lanes();
    conclude();
  end
endmodule
`default_nettype wire

// ---- sim/fif_host.sv ----
// Purpose: host controller model driving select, clock and data
// Assumes: 125 ns serial clock, one data bit per rising edge
// Notes:   captures io_out[1] at each rising edge
`timescale 1ns/1ps
`default_nettype none
module fif_host (
  output logic            cs_n_pin,
  output logic            sclk_pin,
  output logic      [3:0] io_in,
  input  wire logic [3:0] io_out,
  input  wire logic [3:0] io_oe
);
  initial begin
    cs_n_pin = 1'b1;
    sclk_pin = 1'b0;
    io_in    = 4'hA;
  end

  // nb bits sent from d[nb-1] down, then nr clocks of read
  task automatic frame(input logic [63:0] d, input int nb, input int nr, output logic [15:0] q);
    q = 16'h0000;
    cs_n_pin = 1'b0;
    for (int i = 0; i < nb + nr; i++) begin
      sclk_pin = 1'b0;
      if (i < nb) io_in[0] = d[nb - 1 - i];
      #62.5;
      sclk_pin = 1'b1;
      q = {q[14:0], io_out[1] ^ ~io_oe[1]};
      #62.5;
    end
    sclk_pin = 1'b0;
    #62.5;
    cs_n_pin = 1'b1;
    // released lines flip so a stale value never passes
    io_in = ~io_in;
    #250;
  endtask
endmodule
`default_nettype wire
